// *** verilog/seecmd_regs.vh ***
/*
 * Constants of the serial EEPROM command interface: opcodes, field lengths,
 * job encodings and self-timed cycle lengths.
 * Assumes a core clock whose period is given below; included by bare name.
 */
`ifndef SEECMD_REGS_VH
`define SEECMD_REGS_VH

`define SEE_CLK_PERIOD_NS 100
`define SEE_CSL_NS 250
`define SEE_CSL_CYC ((`SEE_CSL_NS + `SEE_CLK_PERIOD_NS - 1) / `SEE_CLK_PERIOD_NS)
`define SEE_WORD_PROG_MS 4
`define SEE_BULK_ERASE_MS 15
`define SEE_BULK_WRITE_MS 30
`define SEE_NS_PER_MS 1000000

`define SEE_OP_SPECIAL 2'h0
`define SEE_OP_WRITE 2'h1
`define SEE_OP_READ 2'h2
`define SEE_OP_ERASE 2'h3
`define SEE_SUB_DISABLE 2'h0
`define SEE_SUB_BULK_WRITE 2'h1
`define SEE_SUB_BULK_ERASE 2'h2
`define SEE_SUB_ENABLE 2'h3

`define SEE_ABITS_X16 5'h08
`define SEE_ABITS_X8 5'h09
`define SEE_DBITS_X16 5'h10
`define SEE_DBITS_X8 5'h08

`define SEE_JOB_WORD_WRITE 2'h0
`define SEE_JOB_WORD_ERASE 2'h1
`define SEE_JOB_BULK_ERASE 2'h2
`define SEE_JOB_BULK_WRITE 2'h3
`define SEE_JOB_W 28
`define SEE_FIFO_DEPTH 32
`define SEE_FIFO_AW 5

`define SEE_ARRAY_WORDS 256
`define SEE_LAST_INDEX 8'hff
`define SEE_ERASED_WORD 16'hffff
`define SEE_MASK_HIGH 16'hff00
`define SEE_MASK_LOW 16'h00ff
`define SEE_TIMER_W 20

`endif

// *** verilog/seecmd_top.v ***
/*
 * Serial EEPROM command interface: three-wire command decoder, read shifter,
 * program-enable latch, queue of programming jobs and self-timed engine.
 * Assumes select, serial clock, data in and the width strap come from
 * outside the core clock domain; the serial clock is far slower than it.
 */
`timescale 1ns/1ps
`include "seecmd_regs.vh"

module seecmd_fifo
#(
	parameter WIDTH = `SEE_JOB_W,
	parameter DEPTH = `SEE_FIFO_DEPTH,
	parameter AW = `SEE_FIFO_AW
)
(
	// Clock and reset.
	input wire i_core_clk,
	input wire i_reset_n,
	// Filling side.
	input wire i_in_valid,
	output wire o_in_ready,
	input wire [WIDTH-1:0] i_in_data,
	// Draining side.
	output wire o_out_valid,
	input wire i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);
	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [AW:0] wr_ptr_reg;
	reg [AW:0] rd_ptr_reg;
	wire empty = (wr_ptr_reg == rd_ptr_reg);
	wire full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
		(wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);

	assign o_in_ready = !full;
	assign o_out_valid = !empty;
	assign o_out_data = store[rd_ptr_reg[AW-1:0]];

	always @(posedge i_core_clk)
	begin
		if (i_in_valid && !full)
			store[wr_ptr_reg[AW-1:0]] <= i_in_data;
	end

	always @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			wr_ptr_reg <= {(AW+1){1'b0}};
			rd_ptr_reg <= {(AW+1){1'b0}};
		end
		else
		begin
			if (i_in_valid && !full)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (i_out_ready && !empty)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end
endmodule // seecmd_fifo

module seecmd_top
#(
	parameter integer WORD_PROG_CYC = `SEE_WORD_PROG_MS * `SEE_NS_PER_MS / `SEE_CLK_PERIOD_NS,
	parameter integer BULK_ERASE_CYC = `SEE_BULK_ERASE_MS * `SEE_NS_PER_MS / `SEE_CLK_PERIOD_NS,
	parameter integer BULK_WRITE_CYC = `SEE_BULK_WRITE_MS * `SEE_NS_PER_MS / `SEE_CLK_PERIOD_NS
)
(
	// Clock and reset.
	input wire i_core_clk,
	input wire i_reset_n,
	// Serial pins from the master.
	input wire i_select,
	input wire i_serial_clk,
	input wire i_serial_in_line,
	input wire i_word_width_strap,
	// Serial data output pin.
	output wire o_serial_out,
	output wire o_serial_out_en_n
);
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_HDR = 5'h02;
	localparam [4:0] ST_DATA = 5'h04;
	localparam [4:0] ST_READ = 5'h08;
	localparam [4:0] ST_DONE = 5'h10;
	localparam [3:0] E_IDLE = 4'h1;
	localparam [3:0] E_ERASE = 4'h2;
	localparam [3:0] E_FILL = 4'h4;
	localparam [3:0] E_WAIT = 4'h8;
	localparam integer CSL_INT = `SEE_CSL_CYC;
	localparam [2:0] CSL_CYC = CSL_INT[2:0];
	localparam [`SEE_TIMER_W-1:0] WORD_T = WORD_PROG_CYC[`SEE_TIMER_W-1:0];
	localparam [`SEE_TIMER_W-1:0] BULK_ERASE_CMD_T = BULK_ERASE_CYC[`SEE_TIMER_W-1:0];
	localparam [`SEE_TIMER_W-1:0] BULK_WRITE_CMD_T = BULK_WRITE_CYC[`SEE_TIMER_W-1:0];

	reg [15:0] array [0:`SEE_ARRAY_WORDS-1];

	reg cs_m_reg, cs_s_reg, cs_d_reg;
	reg sk_m_reg, sk_s_reg, sk_d_reg;
	reg di_m_reg, di_s_reg;
	reg strap_m_reg, strap_s_reg;

	reg [4:0] state_reg;
	reg [4:0] cnt_reg;
	reg [10:0] cmd_sr_reg;
	reg [8:0] addr_reg;
	reg [1:0] op_reg;
	reg [15:0] data_sr_reg;
	reg [15:0] word_sr_reg;
	reg prog_en_reg;
	reg job_armed_reg;
	reg [`SEE_JOB_W-1:0] job_reg;
	reg push_reg;
	reg status_watch_reg;
	reg status_on_reg;
	reg [2:0] cs_low_cnt_reg;
	reg out_reg;
	reg out_en_n_reg;

	reg [3:0] eng_reg;
	reg [`SEE_TIMER_W-1:0] timer_reg;
	reg [7:0] sweep_reg;
	reg [`SEE_JOB_W-1:0] cur_job_reg;

	reg mem_we;
	reg [7:0] mem_idx;
	reg [15:0] mem_wd;
	reg [15:0] mem_mask;

	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [`SEE_JOB_W-1:0] fifo_out_data;

	// Only the second synchroniser stage and its delayed copy feed the edge logic.
	wire sk_rise = sk_s_reg & ~sk_d_reg;
	wire cs_rise = cs_s_reg & ~cs_d_reg;
	wire cs_fall = cs_d_reg & ~cs_s_reg;
	wire wide = strap_s_reg;
	wire [4:0] abits = wide ? `SEE_ABITS_X16 : `SEE_ABITS_X8;
	wire [4:0] dbits = wide ? `SEE_DBITS_X16 : `SEE_DBITS_X8;
	wire [10:0] hdr_new = {cmd_sr_reg[9:0], di_s_reg};
	wire [1:0] hdr_op = wide ? hdr_new[9:8] : hdr_new[10:9];
	wire [8:0] hdr_addr = wide ? {1'b0, hdr_new[7:0]} : hdr_new[8:0];
	wire [1:0] hdr_sub = wide ? hdr_new[7:6] : hdr_new[8:7];
	wire hdr_last = (cnt_reg == abits + 5'h01);
	wire busy = (eng_reg != E_IDLE) || fifo_out_valid || push_reg || job_armed_reg;

	// Word from the array, left aligned; x8 picks the high byte at even addresses.
	function [15:0] fetch;
		input [8:0] a;
		input w;
		reg [15:0] wd;
		begin
			wd = w ? array[a[7:0]] : array[a[8:1]];
			if (w || !a[0])
				fetch = wd;
			else
				fetch = {wd[7:0], 8'h00};
		end
	endfunction

	function [8:0] next_addr;
		input [8:0] a;
		input w;
		begin
			if (w)
				next_addr = {1'b0, a[7:0] + 8'h01};
			else
				next_addr = a + 9'h001;
		end
	endfunction

	assign o_serial_out = out_reg;
	assign o_serial_out_en_n = out_en_n_reg;

	always @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			cs_m_reg <= 1'b0;
			cs_s_reg <= 1'b0;
			cs_d_reg <= 1'b0;
			sk_m_reg <= 1'b0;
			sk_s_reg <= 1'b0;
			sk_d_reg <= 1'b0;
			di_m_reg <= 1'b0;
			di_s_reg <= 1'b0;
			strap_m_reg <= 1'b0;
			strap_s_reg <= 1'b0;
		end
		else
		begin
			cs_m_reg <= i_select;
			cs_s_reg <= cs_m_reg;
			cs_d_reg <= cs_s_reg;
			sk_m_reg <= i_serial_clk;
			sk_s_reg <= sk_m_reg;
			sk_d_reg <= sk_s_reg;
			di_m_reg <= i_serial_in_line;
			di_s_reg <= di_m_reg;
			strap_m_reg <= i_word_width_strap;
			strap_s_reg <= strap_m_reg;
		end
	end

	always @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			state_reg <= ST_IDLE;
			cnt_reg <= 5'h00;
			cmd_sr_reg <= 11'h000;
			addr_reg <= 9'h000;
			op_reg <= `SEE_OP_SPECIAL;
			data_sr_reg <= 16'h0000;
			word_sr_reg <= 16'h0000;
			prog_en_reg <= 1'b0;
			job_armed_reg <= 1'b0;
			job_reg <= {`SEE_JOB_W{1'b0}};
			push_reg <= 1'b0;
			status_watch_reg <= 1'b0;
			status_on_reg <= 1'b0;
			cs_low_cnt_reg <= 3'h0;
			out_reg <= 1'b0;
			out_en_n_reg <= 1'b1;
		end
		else if (!cs_s_reg)
		begin
			// Deselected: the serial clock is ignored and any partial command is lost.
			state_reg <= ST_IDLE;
			out_en_n_reg <= 1'b1;
			status_on_reg <= 1'b0;
			push_reg <= 1'b0;
			if (cs_low_cnt_reg != CSL_CYC)
				cs_low_cnt_reg <= cs_low_cnt_reg + 3'h1;
			if (cs_fall && job_armed_reg)
			begin
				push_reg <= 1'b1;
				job_armed_reg <= 1'b0;
				status_watch_reg <= 1'b1;
			end
		end
		else
		begin
			push_reg <= 1'b0;
			cs_low_cnt_reg <= 3'h0;
			if (cs_rise && status_watch_reg && cs_low_cnt_reg == CSL_CYC)
				status_on_reg <= 1'b1;
			if (status_on_reg)
			begin
				out_reg <= ~busy;
				out_en_n_reg <= 1'b0;
			end
			if (sk_rise)
			begin
				case (state_reg)
				ST_IDLE:
				begin
					if (di_s_reg)
					begin
						// A start bit ends any status display.
						state_reg <= ST_HDR;
						cnt_reg <= 5'h00;
						status_on_reg <= 1'b0;
						status_watch_reg <= 1'b0;
						out_en_n_reg <= 1'b1;
					end
				end
				ST_HDR:
				begin
					cmd_sr_reg <= hdr_new;
					cnt_reg <= cnt_reg + 5'h01;
					if (hdr_last)
					begin
						cnt_reg <= 5'h00;
						addr_reg <= hdr_addr;
						op_reg <= hdr_op;
						state_reg <= ST_DONE;
						case (hdr_op)
						`SEE_OP_READ:
						begin
							state_reg <= ST_READ;
							out_reg <= 1'b0;
							out_en_n_reg <= 1'b0;
							word_sr_reg <= fetch(hdr_addr, wide);
						end
						`SEE_OP_WRITE:
							state_reg <= ST_DATA;
						`SEE_OP_ERASE:
						begin
							if (prog_en_reg && fifo_in_ready)
							begin
								job_armed_reg <= 1'b1;
								job_reg <= {`SEE_JOB_WORD_ERASE, wide, hdr_addr, 16'h0000};
							end
						end
						default:
						begin
							if (hdr_sub == `SEE_SUB_ENABLE)
								prog_en_reg <= 1'b1;
							if (hdr_sub == `SEE_SUB_DISABLE)
								prog_en_reg <= 1'b0;
							if (hdr_sub == `SEE_SUB_BULK_ERASE && prog_en_reg && fifo_in_ready)
							begin
								job_armed_reg <= 1'b1;
								job_reg <= {`SEE_JOB_BULK_ERASE, wide, 9'h000, 16'h0000};
							end
							if (hdr_sub == `SEE_SUB_BULK_WRITE)
								state_reg <= ST_DATA;
						end
						endcase
					end
				end
				ST_DATA:
				begin
					data_sr_reg <= {data_sr_reg[14:0], di_s_reg};
					cnt_reg <= cnt_reg + 5'h01;
					if (cnt_reg == dbits - 5'h01)
					begin
						state_reg <= ST_DONE;
						if (prog_en_reg && fifo_in_ready)
						begin
							job_armed_reg <= 1'b1;
							job_reg[`SEE_JOB_W-1:`SEE_JOB_W-2] <=
								(op_reg == `SEE_OP_WRITE) ? `SEE_JOB_WORD_WRITE :
								`SEE_JOB_BULK_WRITE;
							job_reg[`SEE_JOB_W-3:0] <= {wide, addr_reg,
								data_sr_reg[14:0], di_s_reg};
						end
					end
				end
				ST_READ:
				begin
					out_reg <= word_sr_reg[15];
					word_sr_reg <= {word_sr_reg[14:0], 1'b0};
					cnt_reg <= cnt_reg + 5'h01;
					if (cnt_reg == dbits - 5'h01)
					begin
						cnt_reg <= 5'h00;
						addr_reg <= next_addr(addr_reg, wide);
						word_sr_reg <= fetch(next_addr(addr_reg, wide), wide);
					end
				end
				ST_DONE:
					state_reg <= ST_DONE;
				default:
					state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	seecmd_fifo #(
		.WIDTH(`SEE_JOB_W),
		.DEPTH(`SEE_FIFO_DEPTH),
		.AW(`SEE_FIFO_AW)
	) u_job_fifo (
		.i_core_clk(i_core_clk),
		.i_reset_n(i_reset_n),
		.i_in_valid(push_reg),
		.o_in_ready(fifo_in_ready),
		.i_in_data(job_reg),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(eng_reg == E_IDLE),
		.o_out_data(fifo_out_data)
	);

	// Array write port; x8 word jobs touch one byte lane, x8 bulk fills repeat the byte.
	always @*
	begin
		mem_we = 1'b0;
		mem_idx = sweep_reg;
		mem_wd = `SEE_ERASED_WORD;
		mem_mask = `SEE_ERASED_WORD;
		case (eng_reg)
		E_IDLE:
		begin
			if (fifo_out_valid && fifo_out_data[`SEE_JOB_W-1] == 1'b0)
			begin
				mem_we = 1'b1;
				mem_idx = fifo_out_data[25] ? fifo_out_data[23:16] : fifo_out_data[24:17];
				if (!fifo_out_data[25])
					mem_mask = fifo_out_data[16] ? `SEE_MASK_LOW : `SEE_MASK_HIGH;
				if (fifo_out_data[`SEE_JOB_W-1:`SEE_JOB_W-2] == `SEE_JOB_WORD_WRITE)
					mem_wd = fifo_out_data[25] ? fifo_out_data[15:0] :
						{fifo_out_data[7:0], fifo_out_data[7:0]};
			end
		end
		E_ERASE:
			mem_we = 1'b1;
		E_FILL:
		begin
			mem_we = 1'b1;
			mem_wd = cur_job_reg[25] ? cur_job_reg[15:0] :
				{cur_job_reg[7:0], cur_job_reg[7:0]};
		end
		default:
			mem_we = 1'b0;
		endcase
	end

	always @(posedge i_core_clk)
	begin
		if (mem_we)
			array[mem_idx] <= (array[mem_idx] & ~mem_mask) | (mem_wd & mem_mask);
	end

	// The engine runs on the core clock alone, so no serial clock is needed.
	always @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			eng_reg <= E_IDLE;
			timer_reg <= {`SEE_TIMER_W{1'b0}};
			sweep_reg <= 8'h00;
			cur_job_reg <= {`SEE_JOB_W{1'b0}};
		end
		else
		begin
			if (timer_reg != {`SEE_TIMER_W{1'b0}})
				timer_reg <= timer_reg - 1'b1;
			case (eng_reg)
			E_IDLE:
			begin
				if (fifo_out_valid)
				begin
					cur_job_reg <= fifo_out_data;
					sweep_reg <= 8'h00;
					case (fifo_out_data[`SEE_JOB_W-1:`SEE_JOB_W-2])
					`SEE_JOB_BULK_ERASE:
					begin
						eng_reg <= E_ERASE;
						timer_reg <= BULK_ERASE_CMD_T;
					end
					`SEE_JOB_BULK_WRITE:
					begin
						eng_reg <= E_ERASE;
						timer_reg <= BULK_WRITE_CMD_T;
					end
					default:
					begin
						eng_reg <= E_WAIT;
						timer_reg <= WORD_T;
					end
					endcase
				end
			end
			E_ERASE:
			begin
				sweep_reg <= sweep_reg + 8'h01;
				if (sweep_reg == `SEE_LAST_INDEX)
					eng_reg <= (cur_job_reg[`SEE_JOB_W-1:`SEE_JOB_W-2] ==
						`SEE_JOB_BULK_WRITE) ? E_FILL : E_WAIT;
			end
			E_FILL:
			begin
				sweep_reg <= sweep_reg + 8'h01;
				if (sweep_reg == `SEE_LAST_INDEX)
					eng_reg <= E_WAIT;
			end
			E_WAIT:
			begin
				if (timer_reg == {`SEE_TIMER_W{1'b0}})
					eng_reg <= E_IDLE;
			end
			default:
				eng_reg <= E_IDLE;
			endcase
		end
	end
endmodule // seecmd_top

// *** verification/seecmd_top_assertions.sv ***
/* Checker of the serial pins of seecmd_top, bound into every instance.
 * Assumes the pins change away from core clock edges or by NBA on them. */
`timescale 1ns/1ps
module seecmd_top_checker
#(
	parameter integer WORD_PROG_CYC = 40000,
	parameter integer BULK_ERASE_CYC = 150000,
	parameter integer BULK_WRITE_CYC = 300000
)
(
	// Clock and reset.
	input wire i_core_clk,
	input wire i_reset_n,
	// Serial pins.
	input wire i_select,
	input wire i_serial_clk,
	input wire i_serial_in_line,
	input wire i_word_width_strap,
	input wire o_serial_out,
	input wire o_serial_out_en_n
);
	reg clk_d_reg;
	reg [3:0] since_rise_reg;
	reg [3:0] sel_hi_reg;
	reg [5:0] edge_cnt_reg;
	wire rise = i_serial_clk & ~clk_d_reg;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	// Edges are counted from the start bit so leading noise is not counted.
	always @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			clk_d_reg <= 1'b0;
			since_rise_reg <= 4'hf;
			sel_hi_reg <= 4'h0;
			edge_cnt_reg <= 6'h00;
		end
		else
		begin
			clk_d_reg <= i_serial_clk;
			if (rise)
				since_rise_reg <= 4'h0;
			else if (since_rise_reg != 4'hf)
				since_rise_reg <= since_rise_reg + 4'h1;
			if (!i_select)
				sel_hi_reg <= 4'h0;
			else if (sel_hi_reg != 4'hf)
				sel_hi_reg <= sel_hi_reg + 4'h1;
			if (!i_select)
				edge_cnt_reg <= 6'h00;
			else if (rise && (edge_cnt_reg != 6'h00 || i_serial_in_line) && edge_cnt_reg != 6'h3f)
				edge_cnt_reg <= edge_cnt_reg + 6'h01;
		end
	end
	sequence sel_quiet;
		(!i_select)[*5];
	endsequence
	a_fall_release: assert property (
		$fell(i_select) |-> ##[1:5] o_serial_out_en_n) else $error("no release on select fall");
	a_low_quiet: assert property (
		sel_quiet |-> o_serial_out_en_n) else $error("driving while deselected");
	a_sel_before: assert property (
		$fell(o_serial_out_en_n) |-> $past(i_select) && $past(i_select, 2))
		else $error("drive without select");
	a_dummy_at: assert property (
		$fell(o_serial_out_en_n) && edge_cnt_reg != 6'h00
		|-> edge_cnt_reg == (i_word_width_strap ? 6'h0b : 6'h0c) && !o_serial_out)
		else $error("read output misplaced");
	a_status_only: assert property (
		$fell(o_serial_out_en_n) && edge_cnt_reg == 6'h00 |-> sel_hi_reg inside {[1:6]})
		else $error("drive before start");
	a_drop_cause: assert property (
		$fell(o_serial_out) && !o_serial_out_en_n && !$past(o_serial_out_en_n)
		|-> since_rise_reg <= 4'h5) else $error("output fell without clock");
	a_read_step: assert property (
		$changed(o_serial_out) && !o_serial_out_en_n && !$past(o_serial_out_en_n)
		&& edge_cnt_reg > 6'h0b |-> since_rise_reg <= 4'h5) else $error("read bit moved late");
	a_release_cause: assert property (
		$rose(o_serial_out_en_n) |-> sel_hi_reg <= 4'h5 || edge_cnt_reg == 6'h01)
		else $error("release without cause");
	a_read_holds: assert property (
		edge_cnt_reg > 6'h0b && i_select && !o_serial_out_en_n |=> !i_select || !o_serial_out_en_n)
		else $error("sequential read stopped");
endmodule // seecmd_top_checker
bind seecmd_top seecmd_top_checker #(.WORD_PROG_CYC(WORD_PROG_CYC),
	.BULK_ERASE_CYC(BULK_ERASE_CYC), .BULK_WRITE_CYC(BULK_WRITE_CYC)) u_checker (
	.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_select(i_select),
	.i_serial_clk(i_serial_clk), .i_serial_in_line(i_serial_in_line),
	.i_word_width_strap(i_word_width_strap), .o_serial_out(o_serial_out),
	.o_serial_out_en_n(o_serial_out_en_n));

// *** verification/seecmd_master.sv ***
/* Serial bus master model: drives select, clock and data in, samples data out.
 * Assumes the bench resolves the data-out pin with a pull-up. */
`timescale 1ns/1ps
module seecmd_master
(
	// Core clock for pacing.
	input wire i_core_clk,
	// Resolved data-out pin.
	input wire i_pin,
	// Serial lines to the device.
	output reg o_select,
	output reg o_serial_clk,
	output reg o_serial_in_line
);
	initial
	begin
		o_select = 1'b0;
		o_serial_clk = 1'b0;
		o_serial_in_line = 1'b0;
	end
	task tick(input integer n);
		repeat (n) @(posedge i_core_clk);
	endtask
	// The clock stands low outside frames; each capture sees the bit of the previous rise.
	task xfer(input [63:0] bits, input integer n, output [63:0] got);
		integer k;
		begin
			got = 64'h0;
			tick(1);
			o_select <= 1'b1;
			for (k = n - 1; k >= 0; k = k - 1)
			begin
				tick(4);
				o_serial_clk <= 1'b0;
				o_serial_in_line <= bits[k];
				tick(4);
				got = {got[62:0], i_pin};
				o_serial_clk <= 1'b1;
			end
			tick(4);
			o_serial_clk <= 1'b0;
			tick(4);
			got = {got[62:0], i_pin};
		end
	endtask
	task deselect;
		begin
			tick(1);
			o_select <= 1'b0;
			o_serial_in_line <= 1'b0;
			tick(4);
		end
	endtask
	task status(output r);
		begin
			tick(1);
			o_select <= 1'b1;
			tick(8);
			r = i_pin;
			o_select <= 1'b0;
			tick(4);
		end
	endtask
endmodule // seecmd_master

// *** verification/tb_seecmd_top.sv ***
/* Self-checking bench of seecmd_top with a serial master model.
 * Assumes shortened programming times; one scenario switches to 8-bit words. */
`timescale 1ns/1ps
module tb_seecmd_top;
	localparam integer WP = 600;
	localparam integer BE = 1200;
	localparam integer BW = 1500;
	reg i_core_clk = 1'b0;
	reg i_reset_n = 1'b0;
	reg strap = 1'b1;
	wire sel, sclk, sdi, sdo, sdo_en_n, pin;
	integer bad_count = 0;
	integer compares = 0;
	integer p;
	reg r;
	// The pin has a pull-up, so a released output reads high.
	assign pin = sdo_en_n ? 1'b1 : sdo;
	always #50 i_core_clk = ~i_core_clk;
	seecmd_top #(.WORD_PROG_CYC(WP), .BULK_ERASE_CYC(BE), .BULK_WRITE_CYC(BW)) dut (
		.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_select(sel),
		.i_serial_clk(sclk), .i_serial_in_line(sdi), .i_word_width_strap(strap),
		.o_serial_out(sdo), .o_serial_out_en_n(sdo_en_n));
	seecmd_master m (.i_core_clk(i_core_clk), .i_pin(pin), .o_select(sel),
		.o_serial_clk(sclk), .o_serial_in_line(sdi));
	task complete_run;
		begin
			if (bad_count == 0 && compares > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	task check(input [39:0] got, input [39:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp)
			begin
				bad_count = bad_count + 1;
				$display("FAIL at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task cmd(input [63:0] bits, input integer n);
		reg [63:0] g;
		begin
			m.xfer(bits, n, g);
			m.deselect;
		end
	endtask
	// Two words from a, dummy zero first; z leading zero bits precede the start bit.
	task read2(input [7:0] a, input [31:0] exp, input integer z);
		reg [63:0] g;
		begin
			m.xfer({53'h0, 3'b110, a} << 33, 44 + z, g);
			m.deselect;
			check(g[33:1], {1'b0, exp});
		end
	endtask
	task wait_ready;
		begin
			p = 0;
			r = 1'b0;
			while (r !== 1'b1 && p < 400)
			begin
				m.status(r);
				p = p + 1;
			end
			if (r !== 1'b1)
			begin
				bad_count = bad_count + 1;
				complete_run;
			end
		end
	endtask
	task s_power_up;
		begin
			cmd({37'h0, 3'b101, 8'h03, 16'h1234}, 27);
			m.status(r);
			check(r, 1'b1);
		end
	endtask
	task s_bulk_erase;
		begin
			cmd(64'h4c0, 11);
			cmd(64'h480, 11);
			m.status(r);
			check(r, 1'b0);
			wait_ready;
			check(p * 13 <= BE + 39, 1'b1);
			read2(8'h03, 32'hffffffff, 0);
		end
	endtask
	task s_write_read(input [7:0] a, input [15:0] d, input [15:0] nxt);
		begin
			cmd({37'h0, 3'b101, a, d}, 27);
			m.status(r);
			check(r, 1'b0);
			wait_ready;
			check(p * 13 + 26 >= WP, 1'b1);
			read2(a, {d, nxt}, 0);
		end
	endtask
	task s_erase;
		begin
			cmd({53'h0, 3'b111, 8'h05}, 11);
			m.status(r);
			check(r, 1'b0);
			wait_ready;
			read2(8'h05, 32'hffffffff, 0);
		end
	endtask
	task s_bulk_write;
		begin
			cmd({37'h0, 11'h440, 16'h5a5a}, 27);
			wait_ready;
			read2(8'h07, 32'h5a5a5a5a, 0);
		end
	endtask
	task s_partial;
		begin
			cmd({44'h0, 3'b101, 8'h05, 9'h000}, 20);
			m.status(r);
			check(r, 1'b1);
			read2(8'h05, 32'h5a5a5a5a, 3);
		end
	endtask
	task s_disable;
		begin
			cmd(64'h400, 11);
			cmd({37'h0, 3'b101, 8'h05, 16'h1111}, 27);
			m.status(r);
			check(r, 1'b1);
			read2(8'h05, 32'h5a5a5a5a, 0);
		end
	endtask
	// Byte write to the low half of word 5, then a read of both of its bytes.
	task s_narrow;
		reg [63:0] g;
		begin
			strap <= 1'b0;
			cmd(64'h980, 12);
			cmd({44'h0, 3'b101, 9'h00b, 8'h3c}, 20);
			m.status(r);
			check(r, 1'b0);
			wait_ready;
			m.xfer({52'h0, 3'b110, 9'h00a} << 16, 28, g);
			m.deselect;
			check(g[16:0], {1'b0, 16'h5a3c});
		end
	endtask
	initial
	begin
		repeat (100000) @(posedge i_core_clk);
		bad_count = bad_count + 1;
		complete_run;
	end
	initial
	begin
		repeat (16) @(posedge i_core_clk);
		i_reset_n <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		s_power_up;
		s_bulk_erase;
		s_write_read(8'h05, 16'ha5c3, 16'hffff);
		s_write_read(8'hff, 16'h0f0f, 16'hffff);
		s_erase;
		s_bulk_write;
		s_partial;
		s_disable;
		s_narrow;
		complete_run;
	end
endmodule // tb_seecmd_top
